// file: verilog/dlrc_pkg.sv
// constants, field layouts and carriers for the latch-mode/reference configuration block
// assumes a 100 MHz system clock and a classic wishbone register slave
package dlrc_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SETUP_TIME_US = 200;
    localparam int unsigned SETUP_CYCLES = SETUP_TIME_US * (CLK_HZ / 1_000_000);

    localparam int unsigned CMD_BITS = 24;
    localparam int unsigned CHANNELS = 4;
    localparam int unsigned CMD_RSVD_BIT = 23;
    localparam int unsigned CMD_CODE_HI = 21;
    localparam int unsigned CMD_CODE_LO = 19;
    localparam logic [2:0] CODE_RESTORE = 3'h5;
    localparam logic [2:0] CODE_LATCH_CFG = 3'h6;
    localparam logic [2:0] CODE_REF = 3'h7;
    localparam int unsigned RESTORE_BIT = 0;
    localparam int unsigned KEEP_ALIVE_BIT = 2;

    localparam logic [1:0] REF_EXTERNAL = 2'h0;
    localparam logic [3:0] LATCH_MODE_RST = 4'h0;
    localparam logic [1:0] REF_SEL_RST = 2'h0;
    localparam logic KEEP_ALIVE_RST = 1'b0;

    // register byte addresses and status register bit positions
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_COMMAND = 4'h4;
    localparam int unsigned ST_LATCH_LO = 0;
    localparam int unsigned ST_REF_LO = 4;
    localparam int unsigned ST_KEEP = 6;
    localparam int unsigned ST_READY = 8;
    localparam int unsigned ST_STANDBY = 9;
    localparam int unsigned ST_REF_ON = 10;
    localparam int unsigned ST_SHUTDOWN = 11;

    typedef struct packed {
        logic valid;
        logic [CMD_BITS-1:0] word;
    } dlrc_cmd_s;

    typedef struct packed {
        logic [CHANNELS-1:0] latch_transparent;
        logic [1:0] ref_source;
        logic ref_keep_alive;
    } dlrc_cfg_s;
endpackage : dlrc_pkg

// file: verilog/dlrc_serial_rx.sv
// serial command receiver: 24-bit words, msb first, sampled on rising link clock
// assumes link pins are asynchronous to clk and the link clock is well below clk/4
`timescale 1ns/1ps
module dlrc_serial_rx
(
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic link_frame_n,
    output dlrc_pkg::dlrc_cmd_s cmd
);
    import dlrc_pkg::*;

    logic [1:0] clk_sync;
    logic [1:0] data_sync;
    logic [1:0] frame_sync;
    logic clk_prev;
    logic [CMD_BITS-1:0] shift;
    logic [4:0] count;
    logic clk_rise;
    logic in_frame;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            clk_sync <= 2'h0;
            data_sync <= 2'h0;
            frame_sync <= 2'h3;
            clk_prev <= 1'b0;
        end
        else
        begin
            clk_sync <= {clk_sync[0], link_clk};
            data_sync <= {data_sync[0], link_data};
            frame_sync <= {frame_sync[0], link_frame_n};
            clk_prev <= clk_sync[1];
        end
    end

    assign clk_rise = clk_sync[1] & ~clk_prev;
    assign in_frame = ~frame_sync[1];

    // a frame cut short leaves no partial word behind
    always_ff @(posedge clk)
    begin
        if (srst || !in_frame)
        begin
            count <= 5'h0;
            shift <= '0;
        end
        else if (clk_rise)
        begin
            shift <= {shift[CMD_BITS-2:0], data_sync[1]};
            count <= (count == 5'(CMD_BITS - 1)) ? 5'h0 : count + 5'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmd <= '0;
        end
        else
        begin
            cmd.valid <= in_frame && clk_rise && (count == 5'(CMD_BITS - 1));
            if (in_frame && clk_rise && (count == 5'(CMD_BITS - 1)))
            begin
                cmd.word <= {shift[CMD_BITS-2:0], data_sync[1]};
            end
        end
    end
endmodule : dlrc_serial_rx

// file: verilog/dlrc_top.sv
// latch-mode and reference configuration for a four-channel dac
// assumes a serial command link on pins and a classic wishbone master on clk
`timescale 1ns/1ps
module dlrc_top
#(
    parameter int unsigned SETUP_CYCLES = dlrc_pkg::SETUP_CYCLES
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic link_frame_n,
    input wire logic [3:0] chan_powered_down,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output dlrc_pkg::dlrc_cfg_s cfg,
    output logic force_zero_scale,
    output logic standby,
    output logic ref_powered,
    output logic deep_shutdown
);
    import dlrc_pkg::*;

    dlrc_cmd_s link_cmd;
    dlrc_cmd_s cmd;
    logic [15:0] setup_count;
    logic setup_done;
    logic bus_req;
    logic bus_cmd_write;

    function automatic logic is_cmd(input logic [CMD_BITS-1:0] w, input logic [2:0] code);
        is_cmd = !w[CMD_RSVD_BIT] && (w[CMD_CODE_HI:CMD_CODE_LO] == code);
    endfunction : is_cmd

    dlrc_serial_rx u_rx
    (
        .clk(clk),
        .srst(srst),
        .link_clk(link_clk),
        .link_data(link_data),
        .link_frame_n(link_frame_n),
        .cmd(link_cmd)
    );

    // setup period after power-up; srst stands for power-on
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            setup_count <= 16'h0;
            setup_done <= 1'b0;
        end
        else if (!setup_done)
        begin
            setup_count <= setup_count + 16'h1;
            setup_done <= (setup_count == 16'(SETUP_CYCLES - 1));
        end
    end

    assign force_zero_scale = ~setup_done;

    // a bus command write waits while a link command is being taken, so neither is lost
    assign bus_req = cyc_i && stb_i && !ack_o;
    assign bus_cmd_write = bus_req && we_i && (adr_i == ADR_COMMAND) && (&sel_i[2:0]);

    always_comb
    begin
        cmd = link_cmd;
        if (!link_cmd.valid && bus_cmd_write)
        begin
            cmd.valid = 1'b1;
            cmd.word = dat_i[CMD_BITS-1:0];
        end
        cmd.valid = cmd.valid && setup_done;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cfg.latch_transparent <= LATCH_MODE_RST;
            cfg.ref_source <= REF_SEL_RST;
            cfg.ref_keep_alive <= KEEP_ALIVE_RST;
        end
        else if (cmd.valid)
        begin
            if (is_cmd(cmd.word, CODE_LATCH_CFG))
            begin
                cfg.latch_transparent <= cmd.word[CHANNELS-1:0];
            end
            else if (is_cmd(cmd.word, CODE_REF))
            begin
                cfg.ref_source <= cmd.word[1:0];
                cfg.ref_keep_alive <= cmd.word[KEEP_ALIVE_BIT];
            end
            else if (is_cmd(cmd.word, CODE_RESTORE) && cmd.word[RESTORE_BIT])
            begin
                cfg.latch_transparent <= LATCH_MODE_RST;
                cfg.ref_source <= REF_SEL_RST;
                cfg.ref_keep_alive <= KEEP_ALIVE_RST;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            standby <= 1'b0;
            ref_powered <= 1'b0;
            deep_shutdown <= 1'b0;
        end
        else
        begin
            standby <= &chan_powered_down;
            // an external source leaves the internal reference off
            ref_powered <= (cfg.ref_source != REF_EXTERNAL)
                && !(&chan_powered_down && !cfg.ref_keep_alive);
            deep_shutdown <= &chan_powered_down && !cfg.ref_keep_alive;
        end
    end

    // wishbone slave: ack one cycle after the request, two when a command write meets a link command; unmapped reads give zero
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= bus_req && !(bus_cmd_write && link_cmd.valid);
            dat_o <= 32'h0;
            if (bus_req && !we_i && adr_i == ADR_STATUS)
            begin
                dat_o[ST_LATCH_LO +: CHANNELS] <= cfg.latch_transparent;
                dat_o[ST_REF_LO +: 2] <= cfg.ref_source;
                dat_o[ST_KEEP] <= cfg.ref_keep_alive;
                dat_o[ST_READY] <= setup_done;
                dat_o[ST_STANDBY] <= standby;
                dat_o[ST_REF_ON] <= ref_powered;
                dat_o[ST_SHUTDOWN] <= deep_shutdown;
            end
        end
    end
endmodule : dlrc_top

// file: bench/dlrc_monitor.sv
// monitor: bus handshake, power states and setup hold-off of dlrc_top
// assumes it is bound to dlrc_top and sees only its ports
`timescale 1ns/1ps
module dlrc_monitor
#(
    parameter int unsigned SETUP_CYCLES = dlrc_pkg::SETUP_CYCLES
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] chan_powered_down,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    input dlrc_pkg::dlrc_cfg_s cfg,
    input wire logic force_zero_scale,
    input wire logic standby,
    input wire logic ref_powered,
    input wire logic deep_shutdown
);
    import dlrc_pkg::*;
    logic [15:0] up_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    always_ff @(posedge clk)
    begin
        if (srst)
            up_cnt <= 16'h0;
        else if (up_cnt != 16'hffff)
            up_cnt <= up_cnt + 16'h1;
    end
    AST_ACK_SOON: assert property (cyc_i && stb_i && !ack_o |-> ##[1:2] ack_o)
        else $error("ack late");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack long");
    AST_DAT_QUIET: assert property (!ack_o |-> dat_o == 32'h0) else $error("dat_o busy");
    AST_STANDBY: assert property (!$past(srst) |-> standby == &$past(chan_powered_down))
        else $error("standby wrong");
    AST_KEEP_NO_DEEP: assert property (deep_shutdown |-> !$past(cfg.ref_keep_alive))
        else $error("deep with keep");
    AST_REF_KEPT: assert property ($past(cfg.ref_keep_alive) && $past(cfg.ref_source) != 2'h0
        && !$past(srst) && $stable(cfg) |-> ref_powered) else $error("ref dropped");
    // ref_powered follows the channel states of the previous edge, not the registered standby
    AST_REF_DOWN: assert property (!$past(srst)
        && $past(&chan_powered_down && !cfg.ref_keep_alive) |-> !ref_powered)
        else $error("ref kept");
    AST_ZERO_HOLD: assert property (up_cnt < SETUP_CYCLES |-> force_zero_scale)
        else $error("zero scale early");
    AST_ZERO_END: assert property (up_cnt >= SETUP_CYCLES |-> !force_zero_scale)
        else $error("zero scale late");
endmodule : dlrc_monitor
bind dlrc_top dlrc_monitor #(.SETUP_CYCLES(SETUP_CYCLES)) mon (.clk(clk), .srst(srst),
    .chan_powered_down(chan_powered_down), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .dat_o(dat_o), .cfg(cfg), .force_zero_scale(force_zero_scale), .standby(standby),
    .ref_powered(ref_powered), .deep_shutdown(deep_shutdown));

// file: bench/dlrc_link_host.sv
// link host model: 24-bit words msb first, 160 ns bit period
// assumes the block samples these pins with its own faster clock
`timescale 1ns/1ps
module dlrc_link_host
(
    output logic link_clk,
    output logic link_data,
    output logic link_frame_n
);
    initial
    begin
        link_clk = 1'h0;
        link_data = 1'h1;
        link_frame_n = 1'h1;
    end
    // clock stands still between frames; data then shows the inverse of its last bit
    task automatic send(input logic [23:0] w);
        link_frame_n = 1'h0;
        for (int i = 23; i >= 0; i--)
        begin
            link_data = w[i];
            #80 link_clk = 1'h1;
            #80 link_clk = 1'h0;
        end
        link_data = ~w[0];
        #80 link_frame_n = 1'h1;
    endtask : send
endmodule : dlrc_link_host

// file: bench/test_dlrc_top.sv
// bench for dlrc_top: setup hold-off, config commands over bus and link, power states
// assumes dlrc_link_host and the bound monitor are compiled alongside
`timescale 1ns/1ps
module test_dlrc_top;
    import dlrc_pkg::*;
    logic clk, srst, cyc_i, stb_i, we_i, ack_o, zs, sb, rp, ds, lc, ld, lf;
    logic [3:0] pd, adr_i, sel_i;
    logic [31:0] dat_i, dat_o, q;
    dlrc_cfg_s cfg;
    int errors, check_count;
    dlrc_top #(.SETUP_CYCLES(50)) dut (.clk(clk), .srst(srst), .link_clk(lc), .link_data(ld),
        .link_frame_n(lf), .chan_powered_down(pd), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cfg(cfg),
        .force_zero_scale(zs), .standby(sb), .ref_powered(rp), .deep_shutdown(ds));
    dlrc_link_host host (.link_clk(lc), .link_data(ld), .link_frame_n(lf));
    task automatic close_out();
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        logic got;
        n = 0;
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack_o !== 1'h1 && n < 20);
        got = ack_o;
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        @(posedge clk);
        if (got !== 1'h1)
        begin
            errors++;
            close_out();
        end
    endtask : wb
    task automatic link(input logic [23:0] w);
        host.send(w);
        repeat (8) @(posedge clk);
    endtask : link
    task automatic t_setup();
        chk("cfg", 32'h0, 32'(cfg));
        chk("zero", 32'h1, 32'(zs));
        wb(1'h1, ADR_COMMAND, 32'h0030_000f);
        chk("cfg", 32'h0, 32'(cfg));
        for (int i = 0; i < 100 && zs !== 1'h0; i++)
            @(posedge clk);
        chk("ready", 32'h0, 32'(zs));
        wb(1'h0, ADR_STATUS, 32'h0);
        chk("status", 32'h100, q);
        wb(1'h0, 4'h8, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask : t_setup
    task automatic t_latch();
        logic [23:0] w[4] = '{24'h30_fff5, 24'h30_000a, 24'hb0_000f, 24'h10_000f};
        logic [3:0] e[4] = '{4'h5, 4'ha, 4'ha, 4'ha};
        for (int i = 0; i < 4; i++)
        begin
            wb(1'h1, ADR_COMMAND, {8'h0, w[i]});
            chk("latch", 32'(e[i]), 32'(cfg.latch_transparent));
        end
    endtask : t_latch
    task automatic t_ref();
        for (int s = 0; s < 4; s++)
        begin
            link({21'h0f_ffff, 1'h0, 2'(s)});
            chk("ref", 32'(s), 32'({cfg.ref_source, cfg.ref_keep_alive}) >> 1);
        end
    endtask : t_ref
    task automatic t_power();
        pd <= 4'hf;
        repeat (4) @(posedge clk);
        chk("down", 32'h5, 32'({sb, rp, ds}));
        link(24'h38_0007);
        chk("kept", 32'h6, 32'({sb, rp, ds}));
        pd <= 4'h7;
        repeat (4) @(posedge clk);
        chk("up", 32'h2, 32'({sb, rp, ds}));
    endtask : t_power
    task automatic t_restore();
        wb(1'h1, ADR_COMMAND, 32'h0028_0000);
        chk("clear", 32'h57, 32'(cfg));
        // a command write without all three low byte lanes is acked and dropped
        sel_i <= 4'h3;
        wb(1'h1, ADR_COMMAND, 32'h0030_000f);
        sel_i <= 4'hf;
        chk("sel", 32'h57, 32'(cfg));
        wb(1'h1, ADR_COMMAND, 32'h0028_0001);
        chk("restore", 32'h0, 32'(cfg));
    endtask : t_restore
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        errors = 0;
        check_count = 0;
        srst <= 1'h1;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
        adr_i <= 4'h0;
        sel_i <= 4'hf;
        dat_i <= 32'h0;
        pd <= 4'h0;
        repeat (8) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        t_setup();
        t_latch();
        t_ref();
        t_power();
        t_restore();
        close_out();
    end
endmodule : test_dlrc_top
